// ### hdam_pkg.sv
package hdam_pkg;

   // Register offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CTRL2 = 8'h01;
   localparam logic [7:0] ADDR_MODE = 8'h02;
   localparam logic [7:0] ADDR_PLAY = 8'h03;
   localparam logic [7:0] ADDR_PER_HIGH = 8'h04;
   localparam logic [7:0] ADDR_PER_LOW = 8'h05;
   localparam logic [7:0] ADDR_DIRECT_LEVEL = 8'h06;
   localparam logic [7:0] ADDR_COEFF1 = 8'h07;
   localparam logic [7:0] ADDR_COEFF2 = 8'h08;
   localparam logic [7:0] ADDR_COEFF3 = 8'h09;
   localparam logic [7:0] ADDR_FACTOR_HIGH = 8'h0A;
   localparam logic [7:0] ADDR_FACTOR_LOW = 8'h0B;
   localparam logic [7:0] ADDR_IMP_HIGH = 8'h0C;
   localparam logic [7:0] ADDR_IMP_LOW = 8'h0D;
   localparam logic [7:0] ADDR_STATUS = 8'h0E;
   localparam logic [7:0] ADDR_BEMF_LIMIT = 8'h0F;
   localparam logic [7:0] ADDR_DELAY_HIGH = 8'h10;
   localparam logic [7:0] ADDR_DELAY_LOW = 8'h11;

   // Field positions
   localparam int PLAY_START_BIT = 0;
   localparam int PLAY_STOP_BIT = 1;
   localparam int STAT_FAULT_BIT = 0;

   // Play modes
   localparam logic [1:0] MODE_DIRECT = 2'h0;
   localparam logic [1:0] MODE_PWM = 2'h1;
   localparam logic [1:0] MODE_REG_TRIG = 2'h2;
   localparam logic [1:0] MODE_PIN_TRIG = 2'h3;

   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h07;
   localparam logic [7:0] CTRL2_RST = 8'h00;
   localparam logic [7:0] PER_HIGH_RST = 8'h1D;
   localparam logic [6:0] PER_LOW_RST = 7'h26;
   localparam logic [7:0] COEFF1_RST = 8'h61;
   localparam logic [7:0] COEFF2_RST = 8'hB4;
   localparam logic [7:0] COEFF3_RST = 8'hEC;
   localparam logic [7:0] BEMF_LIMIT_RST = 8'hFF;
   localparam logic [15:0] FACTOR_RST = 16'h0100;

   // Period register step and its length in core clocks
   localparam int PERIOD_LSB_PS = 1333320;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int TICK_CYCLES = PERIOD_LSB_PS / CLK_PERIOD_PS;
   localparam logic [8:0] TICK_LAST = 9'(TICK_CYCLES - 1);

   typedef enum logic [1:0] {ST_IDLE, ST_DRIVE, ST_BRAKE} hdam_state_t;

   typedef struct packed {
      logic follow_on;
      logic accel_on;
      logic brake_on;
      logic amp_loop_on;
      logic bemf_sense_on;
      logic shape_sel;
      logic standalone;
      logic narrow_band;
      logic factor_hold;
      logic calib_off;
      logic delay_hold;
      logic [1:0] cap_setting;
      logic [1:0] res_setting;
      logic [1:0] mode;
      logic [7:0] per_high;
      logic [6:0] per_low;
      logic [7:0] direct_level;
      logic [7:0] coeff1;
      logic [7:0] coeff2;
      logic [7:0] coeff3;
      logic [7:0] bemf_limit;
      logic [7:0] delay_high;
      logic [7:0] delay_low;
   } hdam_cfg_t;

   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] data;
   } hdam_wr_t;

   typedef struct packed {
      logic [1:0] cap_setting;
      logic [1:0] res_setting;
      logic narrow_band;
   } hdam_filter_t;

   typedef struct packed {
      logic sense_on;
      logic delay_hold;
      logic [7:0] delay_high;
      logic [7:0] delay_low;
   } hdam_sense_t;

endpackage

// ### hdam_drive.sv
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// (R1) Braking only after more than three half-periods
// (R2) Measure impedance first half-period, update factor once
// (R3) Impedance readable as high/low register pair
// (R4) Hold plus calib-off skips measurement and update
// (R5) Amplitude loop lowers current on large back-EMF
// (R6) Host clears follow, accel, brake for wideband
// (R7) Period latched at start; live in direct/PWM
// (R8) Period change applied at half-period boundary
// (R9) Host disables sensing and zeroes delays above 300Hz
// (R10) Sixteen points, points 0-4 mirrored per period
// (R11) Point 0 zero, point 4 full, coefficients between
// (R12) Coefficients reset to sine approximation
// (R13) Host sets shape mode, hold, disables loops
// (R14) Standalone clears faults on entering inactive
// (R15) Short stops drive, loop off, goes inactive
// (R16) Half-cycle bit toggles each half-period start
// (R17) Host times direct level writes to toggles
// (R18) Loop filter cap, res and narrow-band settings
// (R19) Host sets narrow band above 1 mH
// (R20) Register writes staged into core domain first
module hdam_drive
   import hdam_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   output logic [7:0] bus_rdata,
   input wire logic play_pin,
   input wire logic [7:0] pwm_level,
   input wire logic [9:0] imp_sample,
   input wire logic [7:0] bemf_level,
   input wire logic short_circuit,
   output logic [7:0] drive_level,
   output logic drive_polarity,
   output logic current_loop_on,
   output logic drive_active,
   output logic braking,
   output logic fault_active,
   output logic half_cycle,
   output logic follow_on,
   output logic accel_on,
   output logic [15:0] voltage_current_factor,
   output hdam_filter_t filter_cfg,
   output hdam_sense_t sense_cfg
);

   hdam_cfg_t cfg_reg, cfg_next;
   hdam_wr_t stage_reg, stage_next;
   hdam_state_t state_reg, state_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [8:0] tick_reg, tick_next;
   logic [10:0] slot_reg, slot_next;
   logic [3:0] point_reg, point_next;
   logic [2:0] halves_reg, halves_next;
   logic [14:0] per_act_reg, per_act_next;
   logic [7:0] amp_reg, amp_next;
   logic [7:0] level_reg, level_next;
   logic [9:0] imp_reg, imp_next;
   logic [15:0] factor_reg, factor_next;
   logic fault_reg, fault_next;
   logic toggle_reg, toggle_next;
   logic loop_reg, loop_next;
   logic start_req, stop_req, tick, slot_done, half_start, skip_cal;
   logic [10:0] slot_len;
   logic [2:0] mirror;
   logic [8:0] shape;
   logic [16:0] product;
   logic [7:0] base_amp;
   logic [7:0] excess;

   assign slot_len = (per_act_reg[14:4] == 11'h000) ? 11'h001 : per_act_reg[14:4];
   assign tick = (tick_reg == TICK_LAST);
   assign slot_done = tick && (slot_reg >= slot_len - 11'h001);
   assign half_start = (state_reg != ST_IDLE) && slot_done && (point_reg[2:0] == 3'h7);
   assign skip_cal = cfg_reg.factor_hold && cfg_reg.calib_off; // R4

   always_comb begin
      // Register side
      cfg_next = cfg_reg;
      stage_next = '{valid: bus_write, addr: bus_addr, data: bus_wdata}; // R20
      start_req = play_pin && (cfg_reg.mode == MODE_PIN_TRIG);
      stop_req = 1'b0;
      factor_next = factor_reg;
      fault_next = fault_reg;
      if (stage_reg.valid) begin // R20
         unique case (stage_reg.addr)
            ADDR_CTRL: begin
               {cfg_next.narrow_band, cfg_next.standalone, cfg_next.shape_sel,
                cfg_next.bemf_sense_on, cfg_next.amp_loop_on, cfg_next.brake_on,
                cfg_next.accel_on, cfg_next.follow_on} = stage_reg.data;
            end
            ADDR_CTRL2: begin
               {cfg_next.res_setting, cfg_next.cap_setting, cfg_next.delay_hold,
                cfg_next.calib_off, cfg_next.factor_hold} = stage_reg.data[6:0]; // R18
            end
            ADDR_MODE: cfg_next.mode = stage_reg.data[1:0];
            ADDR_PLAY: begin
               start_req = stage_reg.data[PLAY_START_BIT] || start_req;
               stop_req = stage_reg.data[PLAY_STOP_BIT];
            end
            ADDR_PER_HIGH: cfg_next.per_high = stage_reg.data;
            ADDR_PER_LOW: cfg_next.per_low = stage_reg.data[6:0];
            ADDR_DIRECT_LEVEL: cfg_next.direct_level = stage_reg.data;
            ADDR_COEFF1: cfg_next.coeff1 = stage_reg.data;
            ADDR_COEFF2: cfg_next.coeff2 = stage_reg.data;
            ADDR_COEFF3: cfg_next.coeff3 = stage_reg.data;
            ADDR_FACTOR_HIGH: factor_next[15:8] = stage_reg.data;
            ADDR_FACTOR_LOW: factor_next[7:0] = stage_reg.data;
            ADDR_STATUS: begin
               if (stage_reg.data[STAT_FAULT_BIT]) begin
                  fault_next = 1'b0;
               end
            end
            ADDR_BEMF_LIMIT: cfg_next.bemf_limit = stage_reg.data;
            ADDR_DELAY_HIGH: cfg_next.delay_high = stage_reg.data;
            ADDR_DELAY_LOW: cfg_next.delay_low = stage_reg.data;
            default: ;
         endcase
      end

      // Readback, one cycle after the strobe
      rdata_next = 8'h00;
      if (bus_read) begin
         unique case (bus_addr)
            ADDR_CTRL: rdata_next = {cfg_reg.narrow_band, cfg_reg.standalone, cfg_reg.shape_sel,
                                     cfg_reg.bemf_sense_on, cfg_reg.amp_loop_on, cfg_reg.brake_on,
                                     cfg_reg.accel_on, cfg_reg.follow_on};
            ADDR_CTRL2: rdata_next = {1'b0, cfg_reg.res_setting, cfg_reg.cap_setting,
                                      cfg_reg.delay_hold, cfg_reg.calib_off, cfg_reg.factor_hold};
            ADDR_MODE: rdata_next = {6'h00, cfg_reg.mode};
            ADDR_PER_HIGH: rdata_next = cfg_reg.per_high;
            ADDR_PER_LOW: rdata_next = {1'b0, cfg_reg.per_low};
            ADDR_DIRECT_LEVEL: rdata_next = cfg_reg.direct_level;
            ADDR_COEFF1: rdata_next = cfg_reg.coeff1;
            ADDR_COEFF2: rdata_next = cfg_reg.coeff2;
            ADDR_COEFF3: rdata_next = cfg_reg.coeff3;
            ADDR_FACTOR_HIGH: rdata_next = factor_reg[15:8];
            ADDR_FACTOR_LOW: rdata_next = factor_reg[7:0];
            ADDR_IMP_HIGH: rdata_next = imp_reg[9:2]; // R3
            ADDR_IMP_LOW: rdata_next = {6'h00, imp_reg[1:0]}; // R3
            ADDR_STATUS: rdata_next = {4'h0, braking, drive_active, toggle_reg, fault_reg}; // R16
            ADDR_BEMF_LIMIT: rdata_next = cfg_reg.bemf_limit;
            ADDR_DELAY_HIGH: rdata_next = cfg_reg.delay_high;
            ADDR_DELAY_LOW: rdata_next = cfg_reg.delay_low;
            default: rdata_next = 8'h00;
         endcase
      end

      // Amplitude for the coming half-period
      base_amp = (cfg_reg.mode == MODE_PWM) ? pwm_level : cfg_reg.direct_level;
      excess = 8'h00;
      if (cfg_reg.amp_loop_on && (bemf_level > cfg_reg.bemf_limit)) begin
         excess = bemf_level - cfg_reg.bemf_limit; // R5
      end

      // Drive engine
      state_next = state_reg;
      tick_next = 9'h000;
      slot_next = slot_reg;
      point_next = point_reg;
      halves_next = halves_reg;
      per_act_next = per_act_reg;
      amp_next = amp_reg;
      imp_next = imp_reg;
      toggle_next = toggle_reg;
      loop_next = loop_reg;
      unique case (state_reg)
         ST_IDLE: begin
            loop_next = 1'b0;
            if (cfg_reg.standalone) begin
               fault_next = 1'b0; // R14
            end
            if (start_req && !(fault_reg && !cfg_reg.standalone)) begin
               state_next = ST_DRIVE;
               loop_next = 1'b1;
               slot_next = 11'h000;
               point_next = 4'h0;
               halves_next = 3'h0;
               per_act_next = {cfg_reg.per_high, cfg_reg.per_low}; // R7
               amp_next = (base_amp > excess) ? base_amp - excess : 8'h00;
               toggle_next = !toggle_reg; // R16
            end
         end
         ST_DRIVE, ST_BRAKE: begin
            tick_next = tick ? 9'h000 : tick_reg + 9'h001;
            if (tick) begin
               slot_next = slot_done ? 11'h000 : slot_reg + 11'h001;
            end
            if (slot_done) begin
               point_next = point_reg + 4'h1; // R10
            end
            if (half_start) begin
               toggle_next = !toggle_reg; // R16
               halves_next = (halves_reg == 3'h4) ? halves_reg : halves_reg + 3'h1;
               amp_next = (base_amp > excess) ? base_amp - excess : 8'h00; // R5
               if (cfg_reg.mode == MODE_DIRECT || cfg_reg.mode == MODE_PWM) begin
                  per_act_next = {cfg_reg.per_high, cfg_reg.per_low}; // R7 R8
               end
               if (state_reg == ST_DRIVE && halves_reg == 3'h0 && !skip_cal) begin
                  imp_next = imp_sample; // R2
                  factor_next = {6'h00, imp_sample}; // R2
               end
               if (state_reg == ST_BRAKE) begin
                  state_next = ST_IDLE;
               end
            end
            if (stop_req && state_reg == ST_DRIVE) begin
               if (cfg_reg.brake_on && halves_reg > 3'h3) begin // R1
                  state_next = ST_BRAKE;
                  slot_next = 11'h000;
                  point_next = 4'h0;
                  tick_next = 9'h000;
                  toggle_next = !toggle_reg;
               end else begin
                  state_next = ST_IDLE;
               end
            end
         end
      endcase
      if (short_circuit) begin // R15
         state_next = ST_IDLE;
         loop_next = 1'b0;
         fault_next = 1'b1;
      end
      if (state_next == ST_IDLE) begin
         tick_next = 9'h000;
         point_next = 4'h0;
      end

      // Shape: points 0..4 then mirrored back down each half-period
      mirror = point_next[2] && (point_next[1:0] != 2'h0) ? 3'(3'h0 - point_next[2:0])
                                                         : point_next[2:0]; // R10
      shape = 9'h100;
      if (cfg_reg.shape_sel) begin
         unique case (mirror)
            3'h0: shape = 9'h000; // R11
            3'h1: shape = {1'b0, cfg_reg.coeff1}; // R11
            3'h2: shape = {1'b0, cfg_reg.coeff2};
            3'h3: shape = {1'b0, cfg_reg.coeff3};
            default: shape = 9'h100; // R11
         endcase
      end
      product = amp_next * shape;
      level_next = (state_next == ST_IDLE) ? 8'h00 : product[15:8];
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cfg_reg <= '{follow_on: CTRL_RST[0], accel_on: CTRL_RST[1], brake_on: CTRL_RST[2],
                      amp_loop_on: CTRL_RST[3], bemf_sense_on: CTRL_RST[4],
                      shape_sel: CTRL_RST[5], standalone: CTRL_RST[6],
                      narrow_band: CTRL_RST[7], factor_hold: CTRL2_RST[0],
                      calib_off: CTRL2_RST[1], delay_hold: CTRL2_RST[2],
                      cap_setting: CTRL2_RST[4:3], res_setting: CTRL2_RST[6:5],
                      mode: MODE_DIRECT, per_high: PER_HIGH_RST, per_low: PER_LOW_RST,
                      direct_level: 8'h00, coeff1: COEFF1_RST, coeff2: COEFF2_RST,
                      coeff3: COEFF3_RST, bemf_limit: BEMF_LIMIT_RST,
                      delay_high: 8'h00, delay_low: 8'h00}; // R12
         stage_reg <= '0;
         state_reg <= ST_IDLE;
         rdata_reg <= 8'h00;
         tick_reg <= 9'h000;
         slot_reg <= 11'h000;
         point_reg <= 4'h0;
         halves_reg <= 3'h0;
         per_act_reg <= {PER_HIGH_RST, PER_LOW_RST};
         amp_reg <= 8'h00;
         level_reg <= 8'h00;
         imp_reg <= 10'h000;
         factor_reg <= FACTOR_RST;
         fault_reg <= 1'b0;
         toggle_reg <= 1'b0;
         loop_reg <= 1'b0;
      end else if (clk_en) begin
         cfg_reg <= cfg_next;
         stage_reg <= stage_next;
         state_reg <= state_next;
         rdata_reg <= rdata_next;
         tick_reg <= tick_next;
         slot_reg <= slot_next;
         point_reg <= point_next;
         halves_reg <= halves_next;
         per_act_reg <= per_act_next;
         amp_reg <= amp_next;
         level_reg <= level_next;
         imp_reg <= imp_next;
         factor_reg <= factor_next;
         fault_reg <= fault_next;
         toggle_reg <= toggle_next;
         loop_reg <= loop_next;
      end
   end

   assign bus_rdata = rdata_reg;
   assign drive_level = level_reg;
   assign drive_polarity = point_reg[3] ^ (state_reg == ST_BRAKE);
   assign current_loop_on = loop_reg;
   assign drive_active = (state_reg != ST_IDLE);
   assign braking = (state_reg == ST_BRAKE);
   assign fault_active = fault_reg;
   assign half_cycle = toggle_reg;
   assign follow_on = cfg_reg.follow_on;
   assign accel_on = cfg_reg.accel_on;
   assign voltage_current_factor = factor_reg;
   assign filter_cfg = '{cap_setting: cfg_reg.cap_setting, res_setting: cfg_reg.res_setting,
                         narrow_band: cfg_reg.narrow_band}; // R18
   assign sense_cfg = '{sense_on: cfg_reg.bemf_sense_on, delay_hold: cfg_reg.delay_hold,
                        delay_high: cfg_reg.delay_high, delay_low: cfg_reg.delay_low};

   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   sequence s_half_step;
      clk_en && half_start;
   endsequence

   property p_brake_gate;
      (clk_en && state_reg == ST_DRIVE && state_next == ST_BRAKE) |-> halves_reg == 3'h4;
   endproperty
   a_brake_gate: assert property (p_brake_gate) else $error("brake before four halves"); // R1

   property p_imp_once;
      !(clk_en && state_reg == ST_DRIVE && halves_reg == 3'h0 && half_start)
         |=> $stable(imp_reg);
   endproperty
   a_imp_once: assert property (p_imp_once) else $error("impedance outside first half"); // R2

   property p_skip_cal;
      (clk_en && skip_cal) |=> $stable(imp_reg);
   endproperty
   a_skip_cal: assert property (p_skip_cal) else $error("impedance updated while skipped"); // R4

   property p_amp_loop;
      (s_half_step and (cfg_reg.amp_loop_on && bemf_level > cfg_reg.bemf_limit
                        && cfg_reg.mode == MODE_DIRECT && cfg_reg.direct_level != 8'h00))
         |=> amp_reg < cfg_reg.direct_level;
   endproperty
   a_amp_loop: assert property (p_amp_loop) else $error("amplitude not reduced"); // R5

   property p_period_step;
      // Start loads the period from idle, so only running cycles are checked
      (clk_en && state_reg == ST_DRIVE && !half_start) |=> $stable(per_act_reg);
   endproperty
   a_period_step: assert property (p_period_step) else $error("period changed mid half"); // R8

   property p_point_zero;
      (drive_active && cfg_reg.shape_sel && point_reg[2:0] == 3'h0) |-> level_reg == 8'h00;
   endproperty
   a_point_zero: assert property (p_point_zero) else $error("point zero not zero"); // R11

   property p_toggle;
      s_half_step |=> toggle_reg != $past(toggle_reg);
   endproperty
   a_toggle: assert property (p_toggle) else $error("half-cycle bit did not toggle"); // R16

   property p_short;
      (clk_en && short_circuit) |=> (state_reg == ST_IDLE && !loop_reg && fault_reg) ##1 1'b1;
   endproperty
   a_short: assert property (p_short) else $error("short not handled"); // R15

   property p_standalone;
      (clk_en && cfg_reg.standalone && state_reg == ST_IDLE && !short_circuit) |=> !fault_reg;
   endproperty
   a_standalone: assert property (p_standalone) else $error("fault kept in standalone"); // R14

endmodule // hdam_drive

// ### hdam_actuator.sv
`timescale 1ns/1ps
module hdam_actuator
   import hdam_pkg::*;
(
   input wire logic drive_active,
   input wire logic current_loop_on,
   input wire logic [9:0] coil_code,
   input wire logic [7:0] swing,
   input wire logic short_req,
   output logic [9:0] imp_sample,
   output logic [7:0] bemf_level,
   output logic short_circuit
);
   // Sense code only valid with current flowing; otherwise the inverted coil code
   assign imp_sample = current_loop_on ? coil_code : ~coil_code;
   // Coasting coil gives no back-EMF
   assign bemf_level = drive_active ? swing : 8'h00;
   // A shorted coil is only detected while the loop drives it
   assign short_circuit = short_req & current_loop_on;
endmodule // hdam_actuator

// ### tb.sv
`timescale 1ns/1ps
module tb
   import hdam_pkg::*;
;
   logic clock, reset_n, bus_write, bus_read, short_req, seen, play_pin;
   logic [7:0] bus_addr, bus_wdata, bus_rdata, drive_level, bemf_level, swing, pwm_level;
   logic [9:0] imp_sample, coil_code;
   logic [15:0] voltage_current_factor;
   logic drive_polarity, current_loop_on, drive_active, braking, fault_active;
   logic half_cycle, follow_on, accel_on, short_circuit;
   hdam_filter_t filter_cfg;
   hdam_sense_t sense_cfg;
   int fail_count, comparisons, n;
   localparam int HALF = 8 * TICK_CYCLES;
   logic [7:0] ra [11] = '{ADDR_CTRL, ADDR_CTRL2, ADDR_PER_HIGH, ADDR_PER_LOW, ADDR_COEFF1,
      ADDR_COEFF2, ADDR_COEFF3, ADDR_FACTOR_HIGH, ADDR_FACTOR_LOW, ADDR_BEMF_LIMIT, 8'h20};
   logic [7:0] re [11] = '{CTRL_RST, CTRL2_RST, PER_HIGH_RST, {1'b0, PER_LOW_RST}, COEFF1_RST,
      COEFF2_RST, COEFF3_RST, FACTOR_RST[15:8], FACTOR_RST[7:0], BEMF_LIMIT_RST, 8'h00};

   hdam_drive u_hdam_drive (.clock(clock), .reset_n(reset_n), .clk_en(1'b1),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
      .bus_read(bus_read), .bus_rdata(bus_rdata), .play_pin(play_pin), .pwm_level(pwm_level),
      .imp_sample(imp_sample), .bemf_level(bemf_level), .short_circuit(short_circuit),
      .drive_level(drive_level), .drive_polarity(drive_polarity),
      .current_loop_on(current_loop_on), .drive_active(drive_active), .braking(braking),
      .fault_active(fault_active), .half_cycle(half_cycle), .follow_on(follow_on),
      .accel_on(accel_on), .voltage_current_factor(voltage_current_factor),
      .filter_cfg(filter_cfg), .sense_cfg(sense_cfg));

   hdam_actuator u_hdam_actuator (.drive_active(drive_active),
      .current_loop_on(current_loop_on), .coil_code(coil_code), .swing(swing),
      .short_req(short_req), .imp_sample(imp_sample), .bemf_level(bemf_level),
      .short_circuit(short_circuit));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic end_sim;
      $display("fail_count %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      bus_addr <= a;
      bus_wdata <= d;
      bus_write <= 1'b1;
      @(posedge clock);
      bus_write <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      bus_addr <= a;
      bus_read <= 1'b1;
      @(posedge clock);
      bus_read <= 1'b0;
      #1;
      chk("bus_rdata", {8'h00, e}, {8'h00, bus_rdata});
   endtask

   // Cycles until half_cycle changes; bounded so a dead drive cannot hang
   task automatic wait_hc(output int cnt);
      logic h;
      @(negedge clock);
      h = half_cycle;
      cnt = 1;
      while (half_cycle === h && cnt < 9000) begin
         @(negedge clock);
         cnt++;
      end
      if (cnt >= 9000) fail_count++;
   endtask

   task automatic settle;
      repeat (4) @(negedge clock);
   endtask

   initial begin
      repeat (60000) @(posedge clock);
      fail_count++;
      end_sim();
   end

   initial begin
      reset_n = 1'b0;
      {bus_write, bus_read, short_req, play_pin} = '0;
      pwm_level = 8'h00;
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
      coil_code = 10'h2A5;
      swing = 8'h00;
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      for (int i = 0; i < 11; i++) rd(ra[i], re[i]);
      wr(8'h20, 8'h5A);
      rd(8'h20, 8'h00);
      wr(ADDR_IMP_HIGH, 8'h33);
      rd(ADDR_IMP_HIGH, 8'h00);
      // Custom shape entry with hold and calibration off
      wr(ADDR_CTRL, 8'h20);
      wr(ADDR_CTRL2, 8'h7F);
      wr(ADDR_PER_HIGH, 8'h00);
      wr(ADDR_PER_LOW, 8'h10);
      wr(ADDR_MODE, 8'(MODE_REG_TRIG));
      settle();
      chk("filter_cfg", 16'h001E, {11'h0, filter_cfg});
      chk("follow accel", 16'h0000, {14'h0, follow_on, accel_on});
      chk("delay_hold", 16'h0001, {15'h0, sense_cfg.delay_hold});
      wr(ADDR_PLAY, 8'h01);
      wait_hc(n);
      chk("start toggle", 16'h0001, {15'h0, n <= 3});
      chk("drive_active", 16'h0001, {15'h0, drive_active});
      chk("point0 level", 16'h0000, {8'h00, drive_level});
      wait_hc(n);
      chk("half length", 16'(HALF), 16'(n));
      chk("polarity", 16'h0001, {15'h0, drive_polarity});
      rd(ADDR_FACTOR_HIGH, 8'h01);
      rd(ADDR_FACTOR_LOW, 8'h00);
      wr(ADDR_PLAY, 8'h02);
      settle();
      chk("stopped", 16'h0000, {15'h0, drive_active});
      // Impedance measured in the first half, factor updated once
      wr(ADDR_CTRL2, 8'h04);
      wr(ADDR_PLAY, 8'h01);
      wait_hc(n);
      wait_hc(n);
      coil_code = 10'h1C3;
      wait_hc(n);
      rd(ADDR_IMP_HIGH, 8'hA9);
      rd(ADDR_IMP_LOW, 8'h01);
      rd(ADDR_FACTOR_HIGH, 8'h02);
      rd(ADDR_FACTOR_LOW, 8'hA5);
      chk("factor port", 16'h02A5, voltage_current_factor);
      wr(ADDR_PLAY, 8'h02);
      // Stop too early for braking, then stop late enough to brake
      wr(ADDR_CTRL, 8'h24);
      wr(ADDR_PLAY, 8'h01);
      wait_hc(n);
      wait_hc(n);
      wr(ADDR_PLAY, 8'h02);
      seen = 1'b0;
      repeat (2300) begin
         @(negedge clock);
         if (braking === 1'b1) seen = 1'b1;
      end
      chk("brake short seq", 16'h0000, {15'h0, seen});
      chk("idle short seq", 16'h0000, {15'h0, drive_active});
      wr(ADDR_PLAY, 8'h01);
      repeat (5) wait_hc(n);
      wr(ADDR_PLAY, 8'h02);
      n = 0;
      while (braking !== 1'b1 && n < 2300) begin
         @(negedge clock);
         n++;
      end
      chk("brake long seq", 16'h0001, {15'h0, braking});
      repeat (2300) @(negedge clock);
      chk("brake ends", 16'h0000, {15'h0, drive_active});
      // Short without standalone: sticky fault blocks playback
      wr(ADDR_CTRL, 8'h20);
      wr(ADDR_PLAY, 8'h01);
      wait_hc(n);
      @(posedge clock);
      short_req <= 1'b1;
      @(posedge clock);
      short_req <= 1'b0;
      settle();
      chk("short stop", 16'h0000, {14'h0, drive_active, current_loop_on});
      chk("fault", 16'h0001, {15'h0, fault_active});
      wr(ADDR_PLAY, 8'h01);
      settle();
      chk("refused", 16'h0000, {15'h0, drive_active});
      wr(ADDR_STATUS, 8'h01);
      settle();
      chk("fault cleared", 16'h0000, {15'h0, fault_active});
      // Standalone clears the fault itself and plays again
      wr(ADDR_CTRL, 8'h60);
      wr(ADDR_PLAY, 8'h01);
      wait_hc(n);
      @(posedge clock);
      short_req <= 1'b1;
      @(posedge clock);
      short_req <= 1'b0;
      settle();
      chk("auto clear", 16'h0000, {14'h0, fault_active, drive_active});
      wr(ADDR_PLAY, 8'h01);
      settle();
      chk("replay", 16'h0001, {15'h0, drive_active});
      wr(ADDR_PLAY, 8'h02);
      // Direct level with amplitude loop, then live period change
      wr(ADDR_CTRL, 8'h88);
      wr(ADDR_MODE, 8'(MODE_DIRECT));
      wr(ADDR_DIRECT_LEVEL, 8'h80);
      wr(ADDR_BEMF_LIMIT, 8'h10);
      swing <= 8'h30;
      wr(ADDR_PLAY, 8'h01);
      wait_hc(n);
      wait_hc(n);
      settle();
      chk("amp loop level", 16'h0060, {8'h00, drive_level});
      chk("narrow_band", 16'h0001, {15'h0, filter_cfg.narrow_band});
      wr(ADDR_PER_LOW, 8'h20);
      wait_hc(n);
      wait_hc(n);
      chk("new half length", 16'(2 * HALF), 16'(n));
      wr(ADDR_PLAY, 8'h02);
      settle();
      // Pin-triggered start, then level taken from the PWM input
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_MODE, 8'(MODE_PIN_TRIG));
      @(posedge clock);
      play_pin <= 1'b1;
      @(posedge clock);
      play_pin <= 1'b0;
      settle();
      chk("pin start", 16'h0001, {15'h0, drive_active});
      wr(ADDR_MODE, 8'(MODE_PWM));
      pwm_level <= 8'h44;
      wait_hc(n);
      settle();
      chk("pwm level", 16'h0044, {8'h00, drive_level});
      wr(ADDR_PLAY, 8'h02);
      settle();
      end_sim();
   end
endmodule // tb
